// file: design/agp_port.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module agp_port
	import agp_pkg::*;
#(
	parameter int LINES = AGP_LINES,
	parameter int DW    = AGP_DW
) (
	// APB slave
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Application I/O lines
	input  wire logic [LINES-1:0] line_in,
	output logic      [LINES-1:0] line_out,
	output logic      [LINES-1:0] line_oe,
	// External capture trigger
	input  wire logic             ext_capture,
	// Pin event
	output logic                  irq
);

	typedef struct packed {
		logic [31:0]                      rdata;
		logic                             ready;
		logic                             err;
		logic [LINES-1:0]                 dout;
		logic [LINES-1:0]                 dir;
		logic [LINES-1:0]                 sync1;
		logic [LINES-1:0]                 sync2;
		logic [LINES-1:0]                 prev;
		logic [LINES-1:0]                 cap;
		logic [LINES-1:0]                 ien;
		logic [LINES-1:0]                 istat;
		logic [LINES-1:0]                 pout;
		logic [LINES-1:0]                 poe;
		logic [1:0]                       itype;
		logic                             cap_src;
		logic                             ext1;
		logic                             ext2;
		logic                             ext_prev;
		logic [AGP_PWM_LINES-1:0]         pmode;
		logic [AGP_CH-1:0][AGP_CTL_W-1:0] ctrl;
		logic [AGP_CH-1:0][DW-1:0]        hi;
		logic [AGP_CH-1:0][DW-1:0]        lo;
		logic [AGP_CH-1:0][DW-1:0]        wid;
		logic [AGP_CH-1:0][DW-1:0]        cnt;
		agp_pwm_state_type [AGP_CH-1:0]   st;
		logic [AGP_CH-1:0]                pwm;
		logic [AGP_PRE_W-1:0]             pre;
		logic                             irq;
	} agp_port_state_type;

	agp_port_state_type s_q;
	agp_port_state_type s_d;

	// One enable pulse per prescaled unit, shared free running counter
	function automatic logic pre_tick(input logic [AGP_PRE_W-1:0] pre, input logic [3:0] code);
		int lim;
		logic t;
		lim = ((code > 4'(AGP_PRE_MAX)) ? AGP_PRE_MAX : int'(code)) + AGP_PRE_BASE;
		t = 1'b1;
		for (int b = 0; b < AGP_PRE_W; b++) begin
			if (b < lim && !pre[b]) begin
				t = 1'b0;
			end
		end
		return t;
	endfunction

	// Channel slots live at 0x40..0xFF, sixteen bytes each
	function automatic logic ch_hit(input logic [11:0] a);
		return a[11:8] == 4'h0 && a[7:4] >= AGP_CH_BASE;
	endfunction

	function automatic int ch_idx(input logic [11:0] a);
		return int'(a[7:4] - AGP_CH_BASE);
	endfunction

	function automatic logic line_hit(input logic [11:0] a);
		return a[11:8] == AGP_LINE_PAGE && int'(a[7:2]) < LINES;
	endfunction

	logic wr;
	logic rd_setup;
	logic [LINES-1:0] rise;
	logic [LINES-1:0] fall;
	logic [LINES-1:0] ev;
	logic [LINES-1:0] clr;
	logic [LINES-1:0] pwm_line;
	logic cap_cmd;
	logic tk;
	logic done;
	logic [31:0] rv;
	logic hit;
	int c;
	int n;

	always_comb begin
		s_d = s_q;
		clr = '0;
		cap_cmd = 1'b0;
		tk = 1'b0;
		done = 1'b0;
		rv = AGP_RST_WORD;
		hit = 1'b0;
		c = 0;
		n = 0;
		wr = psel && penable && s_q.ready && pwrite;
		rd_setup = psel && !penable;

		// Pin synchronisers
		s_d.sync1 = line_in;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		s_d.ext1 = ext_capture;
		s_d.ext2 = s_q.ext1;
		s_d.ext_prev = s_q.ext2;
		s_d.pre = s_q.pre + 1'b1;

		// Register writes
		if (wr) begin
			unique case (paddr)
				AGP_OFS_DOUT:   s_d.dout = pwdata[LINES-1:0];
				AGP_OFS_DIR:    s_d.dir = pwdata[LINES-1:0];
				AGP_OFS_IEN:    s_d.ien = pwdata[LINES-1:0];
				AGP_OFS_ITYPE:  s_d.itype = pwdata[1:0];
				AGP_OFS_ISTAT:  clr = pwdata[LINES-1:0];
				AGP_OFS_PMODE:  s_d.pmode = pwdata[AGP_PWM_LINES-1:0];
				AGP_OFS_CAPCTL: begin
					s_d.cap_src = pwdata[AGP_CAP_SRC];
					cap_cmd = pwdata[AGP_CAP_CMD];
				end
				default: begin
					if (ch_hit(paddr)) begin
						c = ch_idx(paddr);
						unique case (paddr[3:2])
							AGP_CH_CTRL:  s_d.ctrl[c] = pwdata[AGP_CTL_W-1:0];
							AGP_CH_HIGH:  s_d.hi[c] = pwdata[DW-1:0];
							AGP_CH_LOW:   s_d.lo[c] = pwdata[DW-1:0];
							AGP_CH_WIDTH: s_d.wid[c] = pwdata[DW-1:0];
						endcase
					end else if (line_hit(paddr)) begin
						n = int'(paddr[7:2]);
						s_d.dout[n] = |pwdata;
					end
				end
			endcase
		end

		// Capture, software command or external rising edge
		if ((!s_q.cap_src && cap_cmd) || (s_q.cap_src && s_q.ext2 && !s_q.ext_prev)) begin
			s_d.cap = s_q.sync2;
		end

		// Pin events; a new event beats a same-cycle clear
		rise = s_q.sync2 & ~s_q.prev;
		fall = ~s_q.sync2 & s_q.prev;
		unique case (s_q.itype)
			AGP_TRIG_RISE: ev = rise;
			AGP_TRIG_FALL: ev = fall;
			AGP_TRIG_CHANGE,
			AGP_TRIG_BOTH: ev = rise | fall;
		endcase
		ev = ev & s_q.ien & ~s_q.dir;
		s_d.istat = (s_q.istat & ~clr) | ev;
		s_d.irq = |s_d.istat;

		// Modulators
		for (int k = 0; k < AGP_CH; k++) begin
			tk = pre_tick(s_q.pre, s_q.ctrl[k][AGP_CTL_PRE +: 4]);
			if (!s_q.ctrl[k][AGP_CTL_EN]) begin
				s_d.st[k] = AGP_S_IDLE;
				s_d.cnt[k] = '0;
			end else begin
				done = 1'b0;
				unique case (s_q.st[k])
					AGP_S_IDLE: begin
						s_d.cnt[k] = '0;
						s_d.st[k] = s_q.ctrl[k][AGP_CTL_TYPE] ? AGP_S_PULSE : AGP_S_HIGH;
					end
					AGP_S_HIGH: begin
						done = tk && (s_q.cnt[k] + 1'b1 >= s_q.hi[k]);
						if (done) begin
							s_d.st[k] = AGP_S_LOW;
						end
					end
					AGP_S_LOW: begin
						done = tk && (s_q.cnt[k] + 1'b1 >= s_q.lo[k]);
						if (done) begin
							s_d.st[k] = AGP_S_HIGH;
						end
					end
					AGP_S_PULSE: begin
						done = tk && (s_q.cnt[k] + 1'b1 >= s_q.wid[k]);
						if (done) begin
							s_d.st[k] = AGP_S_DONE;
						end
					end
					AGP_S_DONE: s_d.st[k] = AGP_S_DONE;
					default:    s_d.st[k] = AGP_S_IDLE;
				endcase
				if (s_q.st[k] != AGP_S_IDLE) begin
					s_d.cnt[k] = done ? '0 : (tk ? s_q.cnt[k] + 1'b1 : s_q.cnt[k]);
				end
			end
			unique case (s_d.st[k])
				AGP_S_HIGH:  s_d.pwm[k] = 1'b1;
				AGP_S_PULSE: s_d.pwm[k] = s_q.ctrl[k][AGP_CTL_POL];
				AGP_S_DONE:  s_d.pwm[k] = !s_q.ctrl[k][AGP_CTL_POL];
				default:     s_d.pwm[k] = 1'b0;
			endcase
		end

		// Line drive; modulator path only on the low eight lines
		pwm_line = '0;
		for (int l = 0; l < AGP_PWM_LINES; l++) begin
			pwm_line[l] = s_q.pwm[l];
		end
		for (int l = 0; l < AGP_DUAL_LINES; l++) begin
			pwm_line[l] = s_q.pwm[l] | s_q.pwm[l + AGP_PWM_LINES];
		end
		for (int l = 0; l < LINES; l++) begin
			if (l < AGP_PWM_LINES && s_q.pmode[l]) begin
				s_d.pout[l] = pwm_line[l];
			end else begin
				s_d.pout[l] = s_q.dout[l];
			end
		end
		s_d.poe = s_q.dir;

		// Read data taken in the setup phase, one cycle access
		hit = 1'b1;
		unique case (paddr)
			AGP_OFS_DOUT:   rv[LINES-1:0] = s_q.dout;
			AGP_OFS_DIR:    rv[LINES-1:0] = s_q.dir;
			AGP_OFS_PIN:    rv[LINES-1:0] = s_q.sync2;
			AGP_OFS_CAP:    rv[LINES-1:0] = s_q.cap;
			AGP_OFS_CAPCTL: rv[AGP_CAP_SRC] = s_q.cap_src;
			AGP_OFS_IEN:    rv[LINES-1:0] = s_q.ien;
			AGP_OFS_ITYPE:  rv[1:0] = s_q.itype;
			AGP_OFS_ISTAT:  rv[LINES-1:0] = s_q.istat;
			AGP_OFS_PMODE:  rv[AGP_PWM_LINES-1:0] = s_q.pmode;
			default: begin
				if (ch_hit(paddr)) begin
					c = ch_idx(paddr);
					unique case (paddr[3:2])
						AGP_CH_CTRL:  rv[AGP_CTL_W:0] = {s_q.pwm[c], s_q.ctrl[c]};
						AGP_CH_HIGH:  rv[DW-1:0] = s_q.hi[c];
						AGP_CH_LOW:   rv[DW-1:0] = s_q.lo[c];
						AGP_CH_WIDTH: rv[DW-1:0] = s_q.wid[c];
					endcase
				end else if (line_hit(paddr)) begin
					n = int'(paddr[7:2]);
					rv[0] = s_q.dir[n] ? s_q.dout[n] : s_q.sync2[n];
				end else begin
					hit = 1'b0;
				end
			end
		endcase
		s_d.ready = rd_setup;
		// Error stands only beside ready, never on a released bus
		s_d.err = rd_setup && !hit;
		if (rd_setup) begin
			s_d.rdata = pwrite ? AGP_RST_WORD : rv;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			for (int k = 0; k < AGP_CH; k++) begin
				s_q.st[k] <= AGP_S_IDLE;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata   = s_q.rdata;
	assign pready   = s_q.ready;
	assign pslverr  = s_q.err;
	assign line_out = s_q.pout;
	assign line_oe  = s_q.poe;
	assign irq      = s_q.irq;

endmodule // agp_port
`default_nettype wire

// file: pkg/agp_pkg.sv
`default_nettype none
package agp_pkg;
	// Sizes
	localparam int AGP_LINES      = 24;
	localparam int AGP_PWM_LINES  = 8;
	localparam int AGP_DUAL_LINES = 4;
	localparam int AGP_CH         = 12;
	localparam int AGP_DW         = 16;
	localparam int AGP_PRE_W      = 17;
	localparam int AGP_PRE_BASE   = 3;
	localparam int AGP_PRE_MAX    = 14;

	// Register byte offsets
	localparam logic [11:0] AGP_OFS_DOUT   = 12'h000;
	localparam logic [11:0] AGP_OFS_DIR    = 12'h004;
	localparam logic [11:0] AGP_OFS_PIN    = 12'h008;
	localparam logic [11:0] AGP_OFS_CAP    = 12'h00C;
	localparam logic [11:0] AGP_OFS_CAPCTL = 12'h010;
	localparam logic [11:0] AGP_OFS_IEN    = 12'h014;
	localparam logic [11:0] AGP_OFS_ITYPE  = 12'h018;
	localparam logic [11:0] AGP_OFS_ISTAT  = 12'h01C;
	localparam logic [11:0] AGP_OFS_PMODE  = 12'h020;
	localparam logic [3:0]  AGP_CH_BASE    = 4'h4;
	localparam logic [3:0]  AGP_LINE_PAGE  = 4'h1;

	// Per channel word index within its 16-byte slot
	localparam logic [1:0] AGP_CH_CTRL  = 2'h0;
	localparam logic [1:0] AGP_CH_HIGH  = 2'h1;
	localparam logic [1:0] AGP_CH_LOW   = 2'h2;
	localparam logic [1:0] AGP_CH_WIDTH = 2'h3;

	// Field positions
	localparam int AGP_CTL_EN    = 0;
	localparam int AGP_CTL_TYPE  = 1;
	localparam int AGP_CTL_POL   = 2;
	localparam int AGP_CTL_PRE   = 4;
	localparam int AGP_CTL_W     = 8;
	localparam int AGP_CAP_SRC   = 0;
	localparam int AGP_CAP_CMD   = 1;

	// Interrupt trigger codes
	localparam logic [1:0] AGP_TRIG_CHANGE = 2'h0;
	localparam logic [1:0] AGP_TRIG_RISE   = 2'h1;
	localparam logic [1:0] AGP_TRIG_FALL   = 2'h2;
	localparam logic [1:0] AGP_TRIG_BOTH   = 2'h3;

	localparam logic [31:0] AGP_RST_WORD = 32'h0000_0000;

	typedef enum logic [4:0] {
		AGP_S_IDLE  = 5'b00001,
		AGP_S_HIGH  = 5'b00010,
		AGP_S_LOW   = 5'b00100,
		AGP_S_PULSE = 5'b01000,
		AGP_S_DONE  = 5'b10000
	} agp_pwm_state_type;
endpackage
`default_nettype wire

// file: tb/agp_board.sv
`timescale 1ns/1ns
`default_nettype none
module agp_board
	import agp_pkg::*;
(
	// From the port
	input wire logic [AGP_LINES-1:0] line_out,
	input wire logic [AGP_LINES-1:0] line_oe,
	// Board levels on undriven lines
	input wire logic [AGP_LINES-1:0] drive,
	// To the port
	output logic     [AGP_LINES-1:0] line_in
);
	// Board never fights a driven line, so those read back their own level
	assign line_in = (line_out & line_oe) | (drive & ~line_oe);
endmodule // agp_board
`default_nettype wire

// file: tb/agp_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module agp_port_monitor
	import agp_pkg::*;
#(
	parameter int LINES = 24,
	parameter int DW    = 16
) (
	// APB side
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [11:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	// Line side
	input wire logic [LINES-1:0] line_in,
	input wire logic [LINES-1:0] line_out,
	input wire logic [LINES-1:0] line_oe,
	input wire logic             ext_capture,
	input wire logic             irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr = psel && penable && pready && pwrite;
	// Lines 7:0 may be modulator driven, so only the plain ones have their level tied to the DOUT write
	property p_dir;
		logic [23:0] v;
		(wr && paddr == AGP_OFS_DIR, v = pwdata[23:0]) |-> ##2 line_oe[23:0] == v;
	endproperty
	property p_dout;
		logic [15:0] v;
		(wr && paddr == AGP_OFS_DOUT, v = pwdata[23:8]) |-> ##2 line_out[23:8] == v;
	endproperty
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_unmapped: assert property (pready && paddr == 12'hFFC |-> pslverr && prdata == 32'h0)
		else $error("unmapped access accepted");
	a_no_err_mapped: assert property (pready && paddr == AGP_OFS_DIR |-> !pslverr) else $error("mapped refused");
	a_oe_follows_dir: assert property (p_dir) else $error("direction not applied");
	a_dout_drives: assert property (p_dout) else $error("output value not applied");
	a_reset_quiet: assert property ($rose(presetn) |-> line_out == '0 && line_oe == '0 && !irq)
		else $error("outputs active after reset");
	cover property (wr && paddr == AGP_OFS_DIR);
	cover property ($rose(irq));
	cover property (pslverr);
endmodule // agp_port_monitor
`default_nettype wire

// file: tb/test_agp_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_agp_port
	import agp_pkg::*;
;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} agp_row_type;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_capture = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, irq, err;
	logic [23:0] line_in, line_out, line_oe, drive = 0;
	int          errors = 0, checks = 0, i, p, h, l;
	agp_row_type rows [12] = '{'{0, AGP_OFS_DOUT, 0}, '{0, AGP_OFS_DIR, 0}, '{1, AGP_OFS_DIR, 32'h00FF00F0},
		'{0, AGP_OFS_DIR, 32'h00FF00F0}, '{1, AGP_OFS_DOUT, 32'hFFA55A00}, '{0, AGP_OFS_DOUT, 32'h00A55A00},
		'{1, AGP_OFS_IEN, 32'hFFFFFFFF}, '{0, AGP_OFS_IEN, 32'h00FFFFFF}, '{1, AGP_OFS_PMODE, 32'h10},
		'{0, AGP_OFS_PMODE, 32'h10}, '{1, 12'hFFC, 32'h1}, '{0, 12'hFFC, 0}};
	agp_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.line_in, .line_out, .line_oe, .ext_capture, .irq);
	agp_board u_board (.line_out, .line_oe, .drive, .line_in);
	initial begin
		forever #20 pclk = ~pclk;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Idle cycle first, so a release never meets the next setup in one step
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// No wait-state count assumed; the watchdog ends a hung transfer
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(string what, logic [11:0] a, logic [31:0] exp);
		apb(0, a, 0);
		chk(what, exp, rd);
	endtask
	task automatic span(logic lvl, output int c);
		c = 0;
		while (line_out[4] === lvl && c < 5000) begin
			@(posedge pclk);
			c++;
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1, rows[i].a, rows[i].d);
			else rchk("register", rows[i].a, rows[i].d);
		end
		chk("error", 1, err);
		chk("line_oe", 32'h00FF00F0, line_oe);
		$display("registers done");
		apb(1, 12'h140, 0);
		rchk("line value", 12'h140, 0);
		apb(1, 12'h140, 32'h80000000);
		rchk("line value", 12'h140, 1);
		drive <= 24'h003C0F;
		// Two synchroniser stages before the pin register sees it
		repeat (2) @(posedge pclk);
		rchk("pin", AGP_OFS_PIN, 32'h00A53C0F);
		apb(1, AGP_OFS_CAPCTL, 2);
		rchk("capture", AGP_OFS_CAP, 32'h00A53C0F);
		apb(1, AGP_OFS_CAPCTL, 1);
		drive <= 0;
		apb(1, AGP_OFS_CAPCTL, 3);
		rchk("capture", AGP_OFS_CAP, 32'h00A53C0F);
		ext_capture <= 1;
		repeat (6) @(posedge pclk);
		ext_capture <= 0;
		rchk("capture", AGP_OFS_CAP, 32'h00A50000);
		$display("capture done");
		apb(1, AGP_OFS_ISTAT, 32'hFFFFFF);
		for (i = 0; i < 4; i++) begin
			apb(1, AGP_OFS_ITYPE, i);
			for (p = 1; p >= 0; p--) begin
				drive[8] <= p[0];
				repeat (5) @(posedge pclk);
				h = (p == 1 && i != 2) || (p == 0 && i != 1);
				rchk("status", AGP_OFS_ISTAT, h << 8);
				chk("irq", h, irq);
				apb(1, AGP_OFS_ISTAT, 32'h100);
			end
		end
		// Output lines enabled too, so only the direction mask keeps them quiet
		apb(1, AGP_OFS_IEN, 32'hFF0100);
		drive[9] <= 1;
		apb(1, AGP_OFS_DOUT, 0);
		repeat (5) @(posedge pclk);
		rchk("status", AGP_OFS_ISTAT, 0);
		chk("irq", 0, irq);
		$display("interrupts done");
		apb(1, 12'h084, 1);
		apb(1, 12'h088, 2);
		for (p = 0; p < 2; p++) begin
			apb(1, 12'h080, 1 | (p << 4));
			span(0, h);
			span(1, h);
			span(0, h);
			span(1, h);
			span(0, l);
			chk("high", 8 << p, h);
			chk("low", 16 << p, l);
			apb(1, 12'h080, 0);
			repeat (3) @(posedge pclk);
			chk("disabled", 0, line_out[4]);
		end
		apb(1, 12'h08C, 2);
		for (p = 1; p >= 0; p--) begin
			apb(1, 12'h080, 3 | (p << 2));
			repeat (4) @(posedge pclk);
			chk("pulse", p, line_out[4]);
			repeat (60) @(posedge pclk);
			chk("after pulse", !p, line_out[4]);
			apb(1, 12'h080, 0);
		end
		apb(1, AGP_OFS_PMODE, 32'h11);
		apb(1, 12'h0C0, 3);
		repeat (60) @(posedge pclk);
		chk("dual", 1, line_out[0]);
		$display("modulators done");
		presetn <= 0;
		@(posedge pclk);
		chk("reset out", 0, line_out);
		presetn <= 1;
		rchk("reset dir", AGP_OFS_DIR, 0);
		$display("reset done");
		complete_run();
	end
endmodule // test_agp_port
bind agp_port agp_port_monitor #(.LINES(LINES), .DW(DW)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .line_in, .line_out, .line_oe, .ext_capture, .irq);
`default_nettype wire
